/* File: hw/lth_pkg.sv */
// Shared constants and types for the limit-test handler port
package lth_pkg;
   // Reading and limit width (fixed-point stand-in for the numeric range)
   localparam int LTH_DW = 32;
   // Limit defaults: +1.0 and -1.0 in reading units
   localparam logic [31:0] LTH_UPPER_RST = 32'h0000_0001;
   localparam logic [31:0] LTH_LOWER_RST = 32'hffff_ffff;
   // Pattern defaults
   localparam logic [3:0] LTH_PAT_RST = 4'hf;
   // Pattern bit positions: line 4 = weight 8 ... line 1 = weight 1
   localparam int LTH_LINE4_BIT = 3;
   // Output pulse width default, in ns, and its cycle count at 100 MHz
   localparam longint LTH_CLK_NS = 10;
   localparam longint LTH_PW_RST_NS = 100000;
   localparam logic [35:0] LTH_PW_RST_CYC = 36'((LTH_PW_RST_NS + LTH_CLK_NS - 1) / LTH_CLK_NS);
   // Pulse width maximum, 60 s, in cycles
   localparam logic [35:0] LTH_PW_MAX_CYC = 36'(64'd60_000_000_000 / LTH_CLK_NS);
   // End-of-test pulse length in cycles
   localparam logic [7:0] LTH_EOT_CYC = 8'h0a;
   // Error code for a reading request with nothing to return
   localparam logic [15:0] LTH_ERR_NODATA = 16'hff24;
   // Response formats
   typedef enum logic [1:0] {
      LTH_FMT_DEC = 2'b00,
      LTH_FMT_HEX = 2'b01,
      LTH_FMT_OCT = 2'b10,
      LTH_FMT_BIN = 2'b11
   } lth_fmt_e;
   // Arm sources
   typedef enum logic [1:0] {
      LTH_ARM_IMM = 2'b00,
      LTH_ARM_LOW = 2'b01,
      LTH_ARM_HIGH = 2'b10,
      LTH_ARM_EITHER = 2'b11
   } lth_arm_e;
   // Test sequencer states
   typedef enum logic [1:0] {
      LTH_IDLE = 2'b00,
      LTH_ARMED = 2'b01,
      LTH_BUSY = 2'b10
   } lth_state_e;
endpackage

/* File: hw/lth_port.sv */
// Limit comparator, handler output port and reading store
//
// Function
// - Two limit pairs, defaults +1.0 and -1.0
// - Each limit owns a 4-bit fail pattern
// - Per-test fail flag: 0 pass, 1 fail
// - Per-test enable, default off, disabled ignored
// - No enabled failure drives pass pattern
// - Clear pattern, default 15, restores port
// - Immediate clear restores clear pattern
// - Composite auto-clear on each new initiate
// - Output auto-clear after programmable pulse width
// - Line 4 end-of-test or busy mode
// - Busy active level selectable, default low
// - Start per arm source on start line
// - Comparator input: math or sensed path
// - Patterns map bits one-to-one to lines
// - Pattern readback in selected format
// - All readings after last; latest separately
// - Infinite count refuses all-readings request
// - No readings or disabled gives error -220
// - Event status records upper or lower failure
// - Line weights 8,4,2,1; set bit drives high
// - Busy holds line 4; end-of-test pulses it
`timescale 1ns/10ps
module lth_port
   import lth_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter logic [35:0] PW_RST = LTH_PW_RST_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Readings
   input wire logic [LTH_DW-1:0] i_sense_data,
   input wire logic [LTH_DW-1:0] i_math_data,
   input wire logic i_reading_valid,
   input wire logic i_feed_math,
   // Limits, index 0 = limit 1
   input wire logic [LTH_DW-1:0] i_upper1,
   input wire logic [LTH_DW-1:0] i_lower1,
   input wire logic [LTH_DW-1:0] i_upper2,
   input wire logic [LTH_DW-1:0] i_lower2,
   input wire logic i_limits_load,
   input wire logic i_enable1,
   input wire logic i_enable2,
   // Patterns: lower1, upper1, lower2, upper2, pass, clear
   input wire logic [3:0] i_pat_lower1,
   input wire logic [3:0] i_pat_upper1,
   input wire logic [3:0] i_pat_lower2,
   input wire logic [3:0] i_pat_upper2,
   input wire logic [3:0] i_pat_pass,
   input wire logic [3:0] i_pat_clear,
   input wire logic i_pat_load,
   // Clear control
   input wire logic i_clear_now,
   input wire logic i_composite_auto,
   input wire logic i_out_auto,
   input wire logic [35:0] i_pulse_width,
   input wire logic i_cfg_load,
   // Line 4 and arming
   input wire logic i_line4_busy,
   input wire logic i_busy_level_select,
   input wire logic [1:0] i_arm_source,
   input wire logic i_initiate,
   input wire logic i_abort,
   input wire logic [7:0] i_count,
   input wire logic i_count_infinite,
   input wire logic i_start_of_test_line,
   // Pattern readback
   input wire logic [2:0] i_pat_sel,
   input wire logic [1:0] i_format,
   output logic [15:0] o_pat_text,
   // Reading requests
   input wire logic i_req_all,
   input wire logic i_req_latest,
   input wire logic [$clog2(DEPTH)-1:0] i_rd_index,
   output logic [LTH_DW-1:0] o_rd_data,
   output logic o_rd_valid,
   output logic [15:0] o_error,
   output logic o_error_valid,
   // Results
   output logic [3:0] o_out_lines,
   output logic o_fail1,
   output logic o_fail2,
   output logic [3:0] o_limit_event,
   output logic o_busy
);

   ////////////////////////////////////////////////////////////////////////
   // Functions
   // Render a 4-bit pattern as text digits in the chosen format
   function automatic logic [15:0] fmt_pat(input logic [3:0] p, input logic [1:0] f);
      logic [15:0] t;
      t = 16'h0000;
      unique case (f)
         LTH_FMT_DEC: t = (p > 4'h9) ? {8'h00, 4'h1, p - 4'ha} : {12'h000, p};
         LTH_FMT_HEX: t = {12'h000, p};
         LTH_FMT_OCT: t = {8'h00, 1'b0, 2'b00, p[3], 1'b0, p[2:0]};
         LTH_FMT_BIN: t = {3'b000, p[3], 3'b000, p[2], 3'b000, p[1], 3'b000, p[0]};
      endcase
      return t;
   endfunction

   // Signed compare above the upper limit
   function automatic logic above(input logic [LTH_DW-1:0] v, input logic [LTH_DW-1:0] l);
      return $signed(v) > $signed(l);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Configuration state
   logic [LTH_DW-1:0] up1_r, lo1_r, up2_r, lo2_r, up1_nxt, lo1_nxt, up2_nxt, lo2_nxt; // Limits
   logic [3:0] pl1_r, pu1_r, pl2_r, pu2_r, pp_r, pc_r; // Patterns
   logic [3:0] pl1_nxt, pu1_nxt, pl2_nxt, pu2_nxt, pp_nxt, pc_nxt;
   logic [35:0] pw_r, pw_nxt; // Pulse width in cycles

   // Next configuration values on load strobes
   always_comb begin
      up1_nxt = i_limits_load ? i_upper1 : up1_r;
      lo1_nxt = i_limits_load ? i_lower1 : lo1_r;
      up2_nxt = i_limits_load ? i_upper2 : up2_r;
      lo2_nxt = i_limits_load ? i_lower2 : lo2_r;
      pl1_nxt = i_pat_load ? i_pat_lower1 : pl1_r;
      pu1_nxt = i_pat_load ? i_pat_upper1 : pu1_r;
      pl2_nxt = i_pat_load ? i_pat_lower2 : pl2_r;
      pu2_nxt = i_pat_load ? i_pat_upper2 : pu2_r;
      pp_nxt = i_pat_load ? i_pat_pass : pp_r;
      pc_nxt = i_pat_load ? i_pat_clear : pc_r;
      pw_nxt = pw_r;
      if (i_cfg_load) begin
         // Cap at 60 s
         pw_nxt = (i_pulse_width > LTH_PW_MAX_CYC) ? LTH_PW_MAX_CYC : i_pulse_width;
      end
   end

   // Register configuration with documented defaults
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         up1_r <= LTH_UPPER_RST;
         lo1_r <= LTH_LOWER_RST;
         up2_r <= LTH_UPPER_RST;
         lo2_r <= LTH_LOWER_RST;
         pl1_r <= LTH_PAT_RST;
         pu1_r <= LTH_PAT_RST;
         pl2_r <= LTH_PAT_RST;
         pu2_r <= LTH_PAT_RST;
         pp_r <= LTH_PAT_RST;
         pc_r <= LTH_PAT_RST;
         pw_r <= PW_RST;
      end else begin
         up1_r <= up1_nxt;
         lo1_r <= lo1_nxt;
         up2_r <= up2_nxt;
         lo2_r <= lo2_nxt;
         pl1_r <= pl1_nxt;
         pu1_r <= pu1_nxt;
         pl2_r <= pl2_nxt;
         pu2_r <= pu2_nxt;
         pp_r <= pp_nxt;
         pc_r <= pc_nxt;
         pw_r <= pw_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Test sequencer, comparator and output port
   lth_state_e st_r, st_nxt; // Sequencer state
   logic sot_prev_r, sot_prev_nxt; // Previous start line level
   logic [3:0] out_r, out_nxt; // Output lines
   logic [35:0] pwc_r, pwc_nxt; // Pulse-width counter
   logic [7:0] eotc_r, eotc_nxt; // End-of-test pulse counter
   logic [7:0] left_r, left_nxt; // Readings left in this run
   logic fail1_r, fail1_nxt, fail2_r, fail2_nxt;
   logic [3:0] ev_r, ev_nxt; // Upper/lower failure events
   logic [LTH_DW-1:0] mem_r [DEPTH]; // Reading store
   logic [$clog2(DEPTH)-1:0] wp_r, wp_nxt; // Write pointer
   logic [LTH_DW-1:0] last_r, last_nxt; // Latest reading
   logic have_r, have_nxt, done_r, done_nxt; // Any reading; run finished
   logic [LTH_DW-1:0] rd_r, rd_nxt;
   logic rdv_r, rdv_nxt, errv_r, errv_nxt;
   logic [15:0] txt_r, txt_nxt;
   logic [15:0] err_r, err_nxt; // Error code shown with the error strobe
   logic [LTH_DW-1:0] val; // Value under test
   logic [3:0] lf; // Failing limits: lower1, upper1, lower2, upper2
   logic start, take;

   // Next-state logic
   always_comb begin
      val = i_feed_math ? i_math_data : i_sense_data;
      lf[0] = i_enable1 && $signed(val) < $signed(lo1_r);
      lf[1] = i_enable1 && above(val, up1_r);
      lf[2] = i_enable2 && $signed(val) < $signed(lo2_r);
      lf[3] = i_enable2 && above(val, up2_r);
      unique case (i_arm_source)
         LTH_ARM_IMM: start = 1'b1;
         LTH_ARM_LOW: start = sot_prev_r && !i_start_of_test_line;
         LTH_ARM_HIGH: start = !sot_prev_r && i_start_of_test_line;
         LTH_ARM_EITHER: start = sot_prev_r != i_start_of_test_line;
      endcase
      take = (st_r == LTH_BUSY) && i_reading_valid;
      st_nxt = st_r;
      sot_prev_nxt = i_start_of_test_line;
      out_nxt = out_r;
      pwc_nxt = (pwc_r != 36'h0) ? pwc_r - 36'h1 : pwc_r;
      eotc_nxt = (eotc_r != 8'h00) ? eotc_r - 8'h01 : eotc_r;
      left_nxt = left_r;
      fail1_nxt = fail1_r;
      fail2_nxt = fail2_r;
      ev_nxt = ev_r;
      wp_nxt = wp_r;
      last_nxt = last_r;
      have_nxt = have_r;
      done_nxt = done_r;
      // Auto-clear once the pulse width has elapsed
      if (i_out_auto && pwc_r == 36'h1) begin
         out_nxt = pc_r;
      end
      unique case (st_r)
         LTH_IDLE: begin
            if (i_initiate) begin
               st_nxt = LTH_ARMED;
               wp_nxt = '0;
               done_nxt = 1'b0;
               left_nxt = i_count;
               if (i_composite_auto) begin
                  out_nxt = pc_r;
               end
            end
         end
         LTH_ARMED: begin
            if (start) begin
               st_nxt = LTH_BUSY;
            end
         end
         LTH_BUSY: begin
            if (take) begin
               fail1_nxt = lf[0] | lf[1];
               fail2_nxt = lf[2] | lf[3];
               ev_nxt = lf;
               last_nxt = val;
               have_nxt = 1'b1;
               wp_nxt = wp_r + 1'b1;
               // Fixed priority on several failures
               if (lf[0]) out_nxt = pl1_r;
               else if (lf[1]) out_nxt = pu1_r;
               else if (lf[2]) out_nxt = pl2_r;
               else if (lf[3]) out_nxt = pu2_r;
               else out_nxt = pp_r;
               pwc_nxt = (pw_r == 36'h0) ? 36'h1 : pw_r;
               if (!i_count_infinite && left_r <= 8'h01) begin
                  st_nxt = LTH_IDLE;
                  done_nxt = 1'b1;
                  eotc_nxt = LTH_EOT_CYC;
               end else begin
                  left_nxt = left_r - 8'h01;
               end
            end
         end
         default: st_nxt = LTH_IDLE;
      endcase
      if (i_abort) begin
         st_nxt = LTH_IDLE;
      end
      // Immediate clear has the last word on the output pattern
      if (i_clear_now) begin
         out_nxt = pc_r;
         pwc_nxt = 36'h0;
      end
      // Reading requests
      rd_nxt = rd_r;
      rdv_nxt = 1'b0;
      errv_nxt = 1'b0;
      if (i_req_latest || i_req_all) begin
         if (!have_r || !(i_enable1 || i_enable2) || (i_req_all && (i_count_infinite || !done_r))) begin
            errv_nxt = 1'b1;
         end else begin
            rdv_nxt = 1'b1;
            rd_nxt = i_req_all ? mem_r[i_rd_index] : last_r;
         end
      end
      // Error code register, loaded whenever a request is refused
      err_nxt = errv_nxt ? LTH_ERR_NODATA : err_r;
      unique case (i_pat_sel)
         3'h0: txt_nxt = fmt_pat(pl1_r, i_format);
         3'h1: txt_nxt = fmt_pat(pu1_r, i_format);
         3'h2: txt_nxt = fmt_pat(pl2_r, i_format);
         3'h3: txt_nxt = fmt_pat(pu2_r, i_format);
         3'h4: txt_nxt = fmt_pat(pp_r, i_format);
         default: txt_nxt = fmt_pat(pc_r, i_format);
      endcase
   end

   // Register sequencer state
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st_r <= LTH_IDLE;
         sot_prev_r <= 1'b1;
         out_r <= LTH_PAT_RST;
         pwc_r <= 36'h0;
         eotc_r <= 8'h00;
         left_r <= 8'h00;
         fail1_r <= 1'b0;
         fail2_r <= 1'b0;
         ev_r <= 4'h0;
         wp_r <= '0;
         last_r <= '0;
         have_r <= 1'b0;
         done_r <= 1'b0;
         rd_r <= '0;
         rdv_r <= 1'b0;
         errv_r <= 1'b0;
         txt_r <= 16'h0000;
         err_r <= 16'h0000;
      end else begin
         st_r <= st_nxt;
         sot_prev_r <= sot_prev_nxt;
         out_r <= out_nxt;
         pwc_r <= pwc_nxt;
         eotc_r <= eotc_nxt;
         left_r <= left_nxt;
         fail1_r <= fail1_nxt;
         fail2_r <= fail2_nxt;
         ev_r <= ev_nxt;
         wp_r <= wp_nxt;
         last_r <= last_nxt;
         have_r <= have_nxt;
         done_r <= done_nxt;
         rd_r <= rd_nxt;
         rdv_r <= rdv_nxt;
         errv_r <= errv_nxt;
         txt_r <= txt_nxt;
         err_r <= err_nxt;
      end
   end

   // Reading store write, no reset needed for data
   always_ff @(posedge i_clk) begin
      if (take) begin
         mem_r[wp_r] <= val;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output port: line 4 may be overridden by its mode
   logic [3:0] lines_r, lines_nxt;
   logic busy_r, busy_nxt;

   // Next line levels
   always_comb begin
      busy_nxt = (st_nxt != LTH_IDLE);
      lines_nxt = out_nxt;
      if (i_line4_busy) begin
         lines_nxt[LTH_LINE4_BIT] = busy_nxt ? i_busy_level_select : !i_busy_level_select;
      end else begin
         lines_nxt[LTH_LINE4_BIT] = (eotc_nxt != 8'h00) ? 1'b0 : out_nxt[LTH_LINE4_BIT];
      end
   end

   // Register line levels
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         lines_r <= LTH_PAT_RST;
         busy_r <= 1'b0;
      end else begin
         lines_r <= lines_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign o_out_lines = lines_r;
   assign o_fail1 = fail1_r;
   assign o_fail2 = fail2_r;
   assign o_limit_event = ev_r;
   assign o_busy = busy_r;
   assign o_rd_data = rd_r;
   assign o_rd_valid = rdv_r;
   assign o_error = err_r;
   assign o_error_valid = errv_r;
   assign o_pat_text = txt_r;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   clear_now_a: assert property (@(posedge i_clk) disable iff (i_reset)
      i_clear_now |=> out_r == $past(pc_r)) else $error("clear did not restore pattern");
   pass_pat_a: assert property (@(posedge i_clk) disable iff (i_reset)
      take && lf == 4'h0 && !i_clear_now |=> out_r == $past(pp_r)) else $error("pass pattern missing");
   prio_a: assert property (@(posedge i_clk) disable iff (i_reset)
      take && lf[0] && !i_clear_now |=> out_r == $past(pl1_r)) else $error("failure priority wrong");
   fail_flag_a: assert property (@(posedge i_clk) disable iff (i_reset)
      take |=> fail1_r == ($past(lf[0]) | $past(lf[1]))) else $error("fail flag wrong");
   disabled_a: assert property (@(posedge i_clk) disable iff (i_reset)
      take && !i_enable1 |=> !fail1_r) else $error("disabled test failed");
   auto_clr_a: assert property (@(posedge i_clk) disable iff (i_reset)
      st_r == LTH_IDLE && i_initiate && i_composite_auto && !i_abort |=> out_r == $past(pc_r))
      else $error("composite auto-clear missing");
   busy_lvl_a: assert property (@(posedge i_clk) disable iff (i_reset)
      busy_r && i_line4_busy && $stable(i_busy_level_select) |-> lines_r[3] == i_busy_level_select)
      else $error("busy level wrong");
   sequence run_end_s;
      take && !i_count_infinite && left_r <= 8'h01 && !i_abort;
   endsequence
   eot_a: assert property (@(posedge i_clk) disable iff (i_reset)
      run_end_s ##1 !i_line4_busy |-> !lines_r[3]) else $error("end-of-test pulse missing");
   err_a: assert property (@(posedge i_clk) disable iff (i_reset)
      i_req_all && i_count_infinite |=> o_error_valid && !o_rd_valid) else $error("infinite all-read not refused");
endmodule

/* File: test/lth_handler.sv */
// Component handler model that drives the start-of-test line
`timescale 1ns/10ps
module lth_handler (
   // Clock
   input wire logic i_clk,
   // Bench request to start a test
   input wire logic i_go,
   // Start-of-test line towards the port
   output logic o_start_of_test_line
);
   // Cycles left in the low pulse
   logic [3:0] left_r = 4'h0;
   ////////////////////////////////////////////////////////////
   // A request gives a low pulse of 8 cycles: the falling edge serves
   // the low and either sources, the rising edge the high source
   always @(posedge i_clk) begin
      if (i_go) begin
         left_r <= 4'h8;
      end else if (left_r != 4'h0) begin
         left_r <= left_r - 4'h1;
      end
   end
   // Line rests high and is pulled low while the pulse lasts
   assign o_start_of_test_line = (left_r == 4'h0);
endmodule

/* File: test/tb_lth_port.sv */
// Self-checking bench for the limit-test handler port
`timescale 1ns/10ps
module tb_lth_port;
   import lth_pkg::*;
   // Strobe bit positions
   localparam int P_INIT = 0, P_RV = 1, P_LIM = 2, P_PAT = 3, P_CLR = 4;
   localparam int P_CFG = 5, P_ABRT = 6, P_ALL = 7, P_LAT = 8, P_GO = 9;
   // Clock, reset and counters
   logic i_clk, i_reset;
   int fails = 0, checked = 0, cyc = 0;
   // Design inputs
   logic [31:0] sense, math, up1, lo1, up2, lo2;
   logic [3:0] pl1, pu1, pl2, pu2, ppass, pclr, idx, lines, ev;
   logic [9:0] stb;
   logic rv, fm, lim_ld, en1, en2, pat_ld, clr, cauto, oauto, cfg_ld;
   logic l4busy, blvl, init, abrt, inf, req_all, req_lat, go;
   logic [35:0] pw;
   logic [1:0] arm, fmt;
   logic [7:0] cnt;
   logic [2:0] psel;
   // Design outputs
   logic [15:0] txt, err;
   logic [31:0] rd;
   logic rdv, errv, f1, f2, busy, start_of_test_line;
   assign {go, req_lat, req_all, abrt, cfg_ld, clr, pat_ld, lim_ld, rv, init} = stb;
   ////////////////////////////////////////////////////////////
   // Design and handler
   lth_port #(.DEPTH(16), .PW_RST(36'h0_0000_0030)) DUT (.i_clk(i_clk), .i_reset(i_reset),
      .i_sense_data(sense), .i_math_data(math), .i_reading_valid(rv), .i_feed_math(fm),
      .i_upper1(up1), .i_lower1(lo1), .i_upper2(up2), .i_lower2(lo2), .i_limits_load(lim_ld),
      .i_enable1(en1), .i_enable2(en2), .i_pat_lower1(pl1), .i_pat_upper1(pu1),
      .i_pat_lower2(pl2), .i_pat_upper2(pu2), .i_pat_pass(ppass), .i_pat_clear(pclr),
      .i_pat_load(pat_ld), .i_clear_now(clr), .i_composite_auto(cauto), .i_out_auto(oauto),
      .i_pulse_width(pw), .i_cfg_load(cfg_ld), .i_line4_busy(l4busy),
      .i_busy_level_select(blvl), .i_arm_source(arm), .i_initiate(init), .i_abort(abrt),
      .i_count(cnt), .i_count_infinite(inf), .i_start_of_test_line(start_of_test_line), .i_pat_sel(psel),
      .i_format(fmt), .o_pat_text(txt), .i_req_all(req_all), .i_req_latest(req_lat),
      .i_rd_index(idx), .o_rd_data(rd), .o_rd_valid(rdv), .o_error(err),
      .o_error_valid(errv), .o_out_lines(lines), .o_fail1(f1), .o_fail2(f2),
      .o_limit_event(ev), .o_busy(busy));
   lth_handler HND (.i_clk(i_clk), .i_go(go), .o_start_of_test_line(start_of_test_line));
   ////////////////////////////////////////////////////////////
   // 100 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Hang guard: runs need well under 5000 cycles
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////
   // Wait edges, then settle
   task automatic tick(int n = 1);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // One-cycle strobe on a given bit
   task automatic pulse(int b);
      @(posedge i_clk);
      stb[b] <= 1'b1;
      @(posedge i_clk);
      stb[b] <= 1'b0;
      #1;
   endtask
   // Compare one result
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // Offer one reading; the math path carries its negative
   task automatic offer(logic [31:0] v);
      @(posedge i_clk);
      sense <= v;
      math <= -v;
      pulse(P_RV);
   endtask
   // Wait for the run to end, bounded
   task automatic wait_idle();
      int n = 0;
      while (busy !== 1'b0 && n < 50) begin
         tick();
         n++;
      end
      chk(busy, 1'b0);
      if (l4busy === 1'b0) chk(lines[3], 1'b0);
   endtask
   // Single-reading run, then let the end pulse pass
   task automatic run(logic [31:0] v);
      pulse(P_INIT);
      tick(2);
      offer(v);
      wait_idle();
      tick(12);
   endtask
   // Reading request and its answer
   task automatic req(logic all, logic [3:0] i, logic e, logic [31:0] d);
      int n = 0;
      @(posedge i_clk);
      idx <= i;
      pulse(all ? P_ALL : P_LAT);
      while (rdv !== 1'b1 && errv !== 1'b1 && n < 4) begin
         tick();
         n++;
      end
      chk(errv, e);
      chk(rdv, !e);
      chk(e ? {16'h0000, err} : rd, e ? {16'h0000, LTH_ERR_NODATA} : d);
   endtask
   // Counts and verdict
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      logic [15:0] txt_exp [4] = '{16'h0011, 16'h000b, 16'h0013, 16'h1011};
      i_reset = 1'b1;
      stb = '0;
      {sense, math, fm, en1, en2, oauto, l4busy, blvl, inf, arm, fmt, idx} = '0;
      {up1, lo1, up2, lo2} = {32'h0000_000a, 32'hffff_fff6, 32'h0000_0005, 32'hffff_fffb};
      {pl1, pu1, pl2, pu2, ppass, pclr} = {4'h1, 4'hb, 4'h4, 4'h8, 4'h6, 4'h9};
      cauto = 1'b1;
      pw = 36'h0_0000_0014;
      cnt = 8'h01;
      psel = 3'h1;
      repeat (10) @(posedge i_clk);
      i_reset <= 1'b0;
      tick();
      chk(lines, 4'hf);
      chk(f1, 1'b0);
      $display("reset test done");
      @(posedge i_clk) en1 <= 1'b1;
      run(32'h0000_0002);
      chk(f1, 1'b1);
      run(32'h0000_0000);
      chk(f1, 1'b0);
      @(posedge i_clk) en1 <= 1'b0;
      pulse(P_PAT);
      pulse(P_LIM);
      run(32'h0000_0064);
      chk(lines, 4'h6);
      chk(f1, 1'b0);
      $display("default and enable test done");
      @(posedge i_clk) en1 <= 1'b1;
      run(32'h0000_0014);
      chk(lines, 4'hb);
      chk(f1, 1'b1);
      chk(ev, 4'h2);
      run(32'hffff_ffec);
      chk(lines, 4'h1);
      chk(ev, 4'h1);
      @(posedge i_clk) en2 <= 1'b1;
      run(32'hffff_ffec);
      chk(lines, 4'h1);
      chk(f2, 1'b1);
      run(32'h0000_0007);
      chk(lines, 4'h8);
      chk({f2, f1}, 2'h2);
      chk(ev, 4'h8);
      @(posedge i_clk) fm <= 1'b1;
      run(32'hffff_fff9);
      chk(lines, 4'h8);
      @(posedge i_clk) fm <= 1'b0;
      $display("limit test done");
      pulse(P_CLR);
      tick();
      chk(lines, 4'h9);
      run(32'h0000_0014);
      pulse(P_INIT);
      tick(2);
      chk(lines, 4'h9);
      offer(32'h0000_0000);
      wait_idle();
      tick(12);
      chk(lines, 4'h6);
      @(posedge i_clk) oauto <= 1'b1;
      pulse(P_CFG);
      pulse(P_INIT);
      tick(2);
      offer(32'h0000_0014);
      tick(2);
      chk(lines[2:0], 3'h3);
      tick(17);
      chk(lines, 4'hb);
      tick();
      chk(lines, 4'h9);
      @(posedge i_clk) oauto <= 1'b0;
      $display("clear test done");
      @(posedge i_clk) l4busy <= 1'b1;
      for (int l = 0; l < 2; l++) begin
         @(posedge i_clk) blvl <= l[0];
         pulse(P_INIT);
         tick(2);
         chk(lines[3], l[0]);
         offer(32'h0000_0000);
         wait_idle();
         tick(2);
         chk(lines, {~l[0], 3'h6});
      end
      @(posedge i_clk) l4busy <= 1'b0;
      $display("line four test done");
      for (int a = 1; a < 4; a++) begin
         @(posedge i_clk) arm <= a[1:0];
         pulse(P_INIT);
         tick(3);
         offer(32'h0000_0014);
         tick(2);
         chk(lines, 4'h9);
         pulse(P_GO);
         tick(12);
         run_tail: begin
            offer(32'h0000_0000);
            wait_idle();
            tick(12);
         end
         chk(lines, 4'h6);
      end
      @(posedge i_clk) arm <= 2'h0;
      $display("arm test done");
      for (int f = 0; f < 4; f++) begin
         @(posedge i_clk) fmt <= f[1:0];
         tick(3);
         chk(txt, txt_exp[f]);
      end
      $display("readback test done");
      @(posedge i_clk) cnt <= 8'h02;
      pulse(P_INIT);
      tick(2);
      offer(32'h0000_0003);
      req(1'b1, 4'h0, 1'b1, 32'h0);
      offer(32'h0000_0004);
      wait_idle();
      req(1'b1, 4'h0, 1'b0, 32'h0000_0003);
      req(1'b1, 4'h1, 1'b0, 32'h0000_0004);
      req(1'b0, 4'h0, 1'b0, 32'h0000_0004);
      @(posedge i_clk) inf <= 1'b1;
      pulse(P_INIT);
      tick(2);
      offer(32'h0000_0005);
      pulse(P_ABRT);
      tick(2);
      req(1'b1, 4'h0, 1'b1, 32'h0);
      req(1'b0, 4'h0, 1'b0, 32'h0000_0005);
      @(posedge i_clk) {inf, en1, en2} <= 3'h0;
      req(1'b0, 4'h0, 1'b1, 32'h0);
      $display("reading request test done");
      conclude();
   end
endmodule
